// ### design/ssf_sample_fifo.sv
// Sensor sample buffer with mode control, flags, pattern index and byte read-out.
`timescale 1ns/1ps
`default_nettype none

module ssf_obuf #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 32
) (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             flush,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned PW = $clog2(DEPTH);

    // Pointers carry one extra bit so that full and empty can be told apart.
    typedef struct packed {
        logic [PW:0] wp;
        logic [PW:0] rp;
        logic        rdy;
    } ssf_ob_state_t;

    ssf_ob_state_t    s_q;
    ssf_ob_state_t    s_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = s_q.rdy;
    assign out_valid = s_q.wp != s_q.rp;
    assign out_data  = mem[s_q.rp[PW-1:0]];

    always_comb begin
        push = in_valid && s_q.rdy;
        pop  = out_valid && out_ready;
        s_d  = s_q;
        if (flush) begin
            s_d.wp = '0;
            s_d.rp = '0;
        end else begin
            if (push) begin
                s_d.wp = s_q.wp + (PW+1)'(1);
            end
            if (pop) begin
                s_d.rp = s_q.rp + (PW+1)'(1);
            end
        end
        // Ready is registered from the next pointers, so the sensor side
        // sees a flop output that already accounts for this cycle's traffic.
        s_d.rdy = (s_d.wp - s_d.rp) != (PW+1)'(DEPTH);
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[s_q.wp[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '{wp: '0, rp: '0, rdy: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end
endmodule

module ssf_sample_fifo (
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Register port, already in the core clock domain.
    input  wire ssf_pkg::ssf_reg_req_t reg_req,
    output logic [7:0]             reg_rdata,
    // Sample input and mode trigger from the sensor core.
    input  wire ssf_pkg::ssf_sample_t sample_in,
    output logic                   sample_ready,
    input  wire logic              mode_trigger,
    // Words per pattern cycle minus one, from the decimation logic.
    input  wire logic [9:0]        pattern_last
);
    import ssf_pkg::*;

    typedef struct packed {
        logic [7:0]  wm_lo;
        logic [3:0]  wm_hi;
        logic [6:0]  mode_rate;
        logic        stop_wm;
        logic [11:0] wr_ptr;
        logic [11:0] rd_ptr;
        logic [12:0] count;
        logic        overrun;
        logic        stopped;
        logic [9:0]  pattern;
        logic [7:0]  hi_latch;
        logic [7:0]  rdata;
        logic        trig_s1;
        logic        trig_s2;
    } ssf_state_t;

    ssf_state_t       s_q;
    ssf_state_t       s_d;
    logic [15:0]      mem [SSF_DEPTH];
    logic             ob_valid;
    logic [15:0]      ob_data;
    logic             ob_ready;
    logic             store;
    logic [11:0]      wm_level;
    ssf_mode_t        mode;
    ssf_mode_t        eff_mode;
    logic             full_flag;
    logic             wm_flag;
    logic [12:0]      limit;
    logic             at_limit;
    logic             read_word;
    logic             bypassing;
    logic             stop_act;

    // Incoming samples are staged so the sensor side sees back-pressure.
    ssf_obuf #(.WIDTH(SSF_DW), .DEPTH(SSF_OBUF_DEPTH)) u_stage (
        .core_clk  (core_clk),
        .rst       (rst),
        .flush     (bypassing),
        .in_valid  (sample_in.valid),
        .in_ready  (sample_ready),
        .in_data   (sample_in.data),
        .out_valid (ob_valid),
        .out_ready (ob_ready),
        .out_data  (ob_data)
    );

    function automatic logic is_addr(input ssf_reg_req_t r, input logic [6:0] a);
        is_addr = r.addr == a;
    endfunction

    always_comb begin
        wm_level  = {s_q.wm_hi, s_q.wm_lo};
        mode      = ssf_mode_t'(s_q.mode_rate[SSF_MODE_LSB +: 3]);
        // Combined modes follow the trigger level.
        case (mode)
            SSF_MODE_CONT2STOP: eff_mode = s_q.trig_s2 ? SSF_MODE_STOPFULL : SSF_MODE_CONT;
            SSF_MODE_BYP2CONT:  eff_mode = s_q.trig_s2 ? SSF_MODE_CONT : SSF_MODE_BYPASS;
            SSF_MODE_STOPFULL:  eff_mode = SSF_MODE_STOPFULL;
            SSF_MODE_CONT:      eff_mode = SSF_MODE_CONT;
            default:            eff_mode = SSF_MODE_BYPASS;
        endcase
        bypassing = eff_mode == SSF_MODE_BYPASS;
        // With stop-at-watermark and a nonzero watermark the usable size is the watermark level.
        stop_act  = s_q.stop_wm && wm_level != SSF_CNT_ZERO;
        limit     = stop_act ? {1'b0, wm_level} : 13'(SSF_DEPTH);
        // The full buffer is flagged only once its last slot is taken; the
        // watermark limit instead warns one write ahead of being reached.
        at_limit  = (stop_act ? s_q.count + 13'(1) : s_q.count) >= limit;
        // Bypass always reads as plain empty, whatever limit is programmed.
        full_flag = !bypassing && at_limit
                    && (eff_mode != SSF_MODE_CONT || !s_q.stop_wm);
        wm_flag   = !bypassing && (s_q.stop_wm ? (at_limit && eff_mode == SSF_MODE_CONT)
                                : ({1'b0, wm_level} <= s_q.count
                                   && wm_level != SSF_CNT_ZERO));
        read_word = reg_req.rd && is_addr(reg_req, SSF_ADDR_OUT_HI)
                    && s_q.count != 13'(0);
        store     = !bypassing && ob_valid
                    && !(eff_mode == SSF_MODE_STOPFULL
                         && (s_q.count >= limit || s_q.stopped));
        ob_ready  = store || bypassing;

        s_d = s_q;
        s_d.trig_s1 = mode_trigger;
        s_d.trig_s2 = s_q.trig_s1;

        // Reads free room, but a stopped buffer must not refill from the stage.
        if (eff_mode != SSF_MODE_STOPFULL) begin
            s_d.stopped = 1'b0;
        end else if (s_q.count >= limit) begin
            s_d.stopped = 1'b1;
        end

        if (reg_req.wr) begin
            // Writes to status and output registers are ignored.
            case (reg_req.addr)
                SSF_ADDR_WM_LO: s_d.wm_lo     = reg_req.wdata;
                SSF_ADDR_WM_HI: s_d.wm_hi     = reg_req.wdata[3:0];
                SSF_ADDR_MODE:  s_d.mode_rate = reg_req.wdata[6:0];
                SSF_ADDR_CTRL4: s_d.stop_wm   = reg_req.wdata[SSF_STOP_WM_BIT];
                default:        s_d.mode_rate = s_d.mode_rate;
            endcase
        end

        // Reading the low byte latches the high byte of the same word.
        if (reg_req.rd) begin
            case (reg_req.addr)
                SSF_ADDR_WM_LO:  s_d.rdata = s_q.wm_lo;
                SSF_ADDR_WM_HI:  s_d.rdata = {4'h0, s_q.wm_hi};
                SSF_ADDR_MODE:   s_d.rdata = {1'b0, s_q.mode_rate};
                SSF_ADDR_CTRL4:  s_d.rdata = {7'h00, s_q.stop_wm};
                SSF_ADDR_CNT_LO: s_d.rdata = full_flag ? SSF_BYTE_ZERO : s_q.count[7:0];
                SSF_ADDR_CNT_HI: s_d.rdata = {wm_flag, s_q.overrun, full_flag,
                                              s_q.count == 13'(0),
                                              full_flag ? 4'h0 : s_q.count[11:8]};
                SSF_ADDR_PAT_LO: s_d.rdata = s_q.pattern[7:0];
                SSF_ADDR_PAT_HI: s_d.rdata = {6'h00, s_q.pattern[9:8]};
                SSF_ADDR_OUT_LO: begin
                    s_d.rdata    = mem[s_q.rd_ptr][7:0];
                    s_d.hi_latch = mem[s_q.rd_ptr][15:8];
                end
                SSF_ADDR_OUT_HI: s_d.rdata = s_q.hi_latch;
                default:         s_d.rdata = SSF_BYTE_ZERO;
            endcase
        end

        if (read_word) begin
            s_d.rd_ptr  = s_q.rd_ptr + SSF_CNT_ONE;
            s_d.count   = s_q.count - 13'(1);
            s_d.overrun = 1'b0;
            s_d.pattern = (s_q.pattern >= pattern_last) ? SSF_PAT_ZERO
                                                        : s_q.pattern + SSF_PAT_ONE;
        end

        if (store) begin
            s_d.wr_ptr = s_q.wr_ptr + SSF_CNT_ONE;
            if (s_q.count >= limit) begin
                // Overwrite oldest: read side skips the lost word.
                s_d.rd_ptr  = s_d.rd_ptr + SSF_CNT_ONE;
                s_d.overrun = 1'b1;
                s_d.count   = s_d.count;
            end else begin
                s_d.count = s_d.count + 13'(1);
            end
        end

        if (bypassing) begin
            s_d.wr_ptr  = SSF_CNT_ZERO;
            s_d.rd_ptr  = SSF_CNT_ZERO;
            s_d.count   = 13'(0);
            s_d.overrun = 1'b0;
            s_d.pattern = SSF_PAT_ZERO;
        end
    end

    always_ff @(posedge core_clk) begin
        if (store) begin
            mem[s_q.wr_ptr] <= ob_data;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
endmodule

`default_nettype wire

// ### design/ssf_pkg.sv
// Package with register map, field layout, modes and carrier types for the sample buffer.
package ssf_pkg;

    localparam int unsigned SSF_DEPTH   = 4096;
    localparam int unsigned SSF_AW      = 12;
    localparam int unsigned SSF_DW      = 16;
    localparam int unsigned SSF_PAT_W   = 10;
    localparam int unsigned SSF_OBUF_DEPTH = 32;

    // Register addresses on the serial register port.
    localparam logic [6:0] SSF_ADDR_WM_LO    = 7'h06;
    localparam logic [6:0] SSF_ADDR_WM_HI    = 7'h07;
    localparam logic [6:0] SSF_ADDR_MODE     = 7'h0a;
    localparam logic [6:0] SSF_ADDR_CTRL4    = 7'h13;
    localparam logic [6:0] SSF_ADDR_CNT_LO   = 7'h3a;
    localparam logic [6:0] SSF_ADDR_CNT_HI   = 7'h3b;
    localparam logic [6:0] SSF_ADDR_PAT_LO   = 7'h3c;
    localparam logic [6:0] SSF_ADDR_PAT_HI   = 7'h3d;
    localparam logic [6:0] SSF_ADDR_OUT_LO   = 7'h3e;
    localparam logic [6:0] SSF_ADDR_OUT_HI   = 7'h3f;

    // Field positions.
    localparam int unsigned SSF_MODE_LSB     = 0;
    localparam int unsigned SSF_RATE_LSB     = 3;
    localparam int unsigned SSF_STOP_WM_BIT  = 0;
    localparam int unsigned SSF_FLAG_WM_BIT  = 7;
    localparam int unsigned SSF_FLAG_OVR_BIT = 6;
    localparam int unsigned SSF_FLAG_FULL_BIT = 5;
    localparam int unsigned SSF_FLAG_EMPTY_BIT = 4;

    localparam logic [7:0]  SSF_BYTE_ZERO    = 8'h00;
    localparam logic [11:0] SSF_CNT_ZERO     = 12'h000;
    localparam logic [11:0] SSF_CNT_ONE      = 12'h001;
    localparam logic [11:0] SSF_CNT_MAX      = 12'hfff;
    localparam logic [9:0]  SSF_PAT_ZERO     = 10'h000;
    localparam logic [9:0]  SSF_PAT_ONE      = 10'h001;
    // Words in one pattern cycle minus one (three axes per data set, default one set).
    localparam logic [9:0]  SSF_PAT_LAST_DEF = 10'h002;

    typedef enum logic [2:0] {
        SSF_MODE_BYPASS   = 3'b000,
        SSF_MODE_STOPFULL = 3'b001,
        SSF_MODE_RSV2     = 3'b010,
        SSF_MODE_CONT2STOP = 3'b011,
        SSF_MODE_BYP2CONT = 3'b100,
        SSF_MODE_RSV5     = 3'b101,
        SSF_MODE_CONT     = 3'b110,
        SSF_MODE_RSV7     = 3'b111
    } ssf_mode_t;

    // Register access from the serial port decoder.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } ssf_reg_req_t;

    // One sample word from the sensor side.
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } ssf_sample_t;

endpackage

// ### dv/ssf_sample_fifo_chk.sv
// Checker for the sample buffer register port and sample handshake.
`timescale 1ns/1ps
`default_nettype none
module ssf_sample_fifo_chk (
    // Clock and reset.
    input wire logic                  core_clk,
    input wire logic                  rst,
    // Register port.
    input wire ssf_pkg::ssf_reg_req_t reg_req,
    input wire logic [7:0]            reg_rdata,
    // Sample side.
    input wire ssf_pkg::ssf_sample_t  sample_in,
    input wire logic                  sample_ready,
    input wire logic                  mode_trigger,
    input wire logic [9:0]            pattern_last
);
    import ssf_pkg::*;

    // Cycles spent in bypass since it was chosen, saturating; zero in any other mode.
    logic [2:0] byp_q;
    logic       rd_hi;

    assign rd_hi = reg_req.rd && reg_req.addr == SSF_ADDR_CNT_HI;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            byp_q <= 3'h1;
        end else if (reg_req.wr && reg_req.addr == SSF_ADDR_MODE) begin
            byp_q <= (reg_req.wdata[2:0] == 3'h0) ? 3'h1 : 3'h0;
        end else if (byp_q != 3'h0 && byp_q != 3'h7) begin
            byp_q <= byp_q + 3'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_rdata_holds: assert property (!reg_req.rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_bypass_status: assert property (byp_q == 3'h7 && rd_hi |=> reg_rdata == 8'h10)
        else $error("bypass status not empty");
    a_bypass_ready: assert property (byp_q == 3'h7 |-> sample_ready)
        else $error("bypass not draining samples");
    a_ready_after_rst: assert property ($past(rst) |-> sample_ready)
        else $error("no room after reset");
    a_pat_hi_zero: assert property (reg_req.rd && reg_req.addr == SSF_ADDR_PAT_HI
        |=> reg_rdata[7:2] == 6'h00)
        else $error("pattern high unused bits set");
    a_unmapped_zero: assert property (reg_req.rd && reg_req.addr < 7'h06 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_full_cnt_zero: assert property (rd_hi |=> reg_rdata[5] |-> reg_rdata[3:0] == 4'h0)
        else $error("count not zero while full");
    a_full_not_empty: assert property (rd_hi |=> !(reg_rdata[5] && reg_rdata[4]))
        else $error("full and empty together");

    c_full: cover property (rd_hi ##1 reg_rdata[5]);
    c_overrun: cover property (rd_hi ##1 reg_rdata[6]);
    c_refused: cover property (sample_in.valid && !sample_ready);
endmodule

bind ssf_sample_fifo ssf_sample_fifo_chk u_chk (.core_clk(core_clk), .rst(rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .sample_in(sample_in),
    .sample_ready(sample_ready), .mode_trigger(mode_trigger), .pattern_last(pattern_last));
`default_nettype wire

// ### dv/ssf_host_model.sv
// Host processor model driving the register port of the sample buffer.
`timescale 1ns/1ps
`default_nettype none
module ssf_host_model (
    // Clock.
    input wire logic                  core_clk,
    // Register port.
    output var ssf_pkg::ssf_reg_req_t reg_req,
    input wire logic [7:0]            reg_rdata
);
    import ssf_pkg::*;

    initial begin
        reg_req = '0;
    end

    // Idle address and data are inverted so a stale value is never mistaken for a request.
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge core_clk);
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        acc(1'b0, a, 8'h00);
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    // Reads whole words and drops them, as the host does with a set it cannot trust.
    task automatic drop_set(input int n);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            rd(SSF_ADDR_OUT_LO, d);
            rd(SSF_ADDR_OUT_HI, d);
        end
    endtask

    // Decimation first, then a pass through bypass, then rate with the new mode.
    task automatic cfg(input logic [2:0] m);
        wr(7'h08, 8'h09);
        wr(SSF_ADDR_MODE, 8'h20);
        wr(SSF_ADDR_MODE, {5'h04, m});
    endtask
endmodule
`default_nettype wire

// ### dv/test_ssf_sample_fifo.sv
// Self-checking bench for the sample buffer modes, flags and read-out.
`timescale 1ns/1ps
`default_nettype none
module test_ssf_sample_fifo;
    import ssf_pkg::*;
    logic         core_clk;
    logic         rst;
    ssf_reg_req_t reg_req;
    logic [7:0]   reg_rdata;
    ssf_sample_t  sample_in;
    logic         sample_ready;
    logic         mode_trigger;
    int           n_fail;
    int           tests_run;

    ssf_sample_fifo dut (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .sample_in(sample_in), .sample_ready(sample_ready),
        .mode_trigger(mode_trigger), .pattern_last(SSF_PAT_LAST_DEF));
    ssf_host_model host (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

    always #20 core_clk = ~core_clk;

    task automatic conclude();
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rchk(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        logic [7:0] g;
        host.rd(a, g);
        cmp($sformatf("reg_%h", a), e, g & m);
    endtask

    // Sample number k carries low byte 10h+k and high byte c3h+k.
    task automatic push(input int n, output int got);
        got = 0;
        for (int c = 0; c < n + 40 && got < n; c++) begin
            @(negedge core_clk);
            sample_in = '{valid: 1'b1, data: {8'hc3 + got[7:0], 8'h10 + got[7:0]}};
            if (sample_ready === 1'b1) got++;
        end
        @(negedge core_clk);
        sample_in = '{valid: 1'b0, data: ~sample_in.data};
    endtask

    task automatic t_reset();
        repeat (8) @(negedge core_clk);
        rchk(SSF_ADDR_CNT_HI, 8'h10);
        rchk(SSF_ADDR_CNT_LO, 8'h00);
        rchk(SSF_ADDR_PAT_LO, 8'h00);
        rchk(7'h00, 8'h00);
    endtask

    task automatic t_stopfull();
        int got;
        host.wr(SSF_ADDR_WM_LO, 8'h04);
        host.wr(SSF_ADDR_WM_HI, 8'h00);
        host.wr(SSF_ADDR_CTRL4, 8'h01);
        host.cfg(SSF_MODE_STOPFULL);
        push(50, got);
        cmp("refused", 8'h01, {7'h0, got < 50 && sample_ready === 1'b0});
        rchk(SSF_ADDR_CNT_HI, 8'h20, 8'h3f);
        rchk(SSF_ADDR_CNT_LO, 8'h00);
        for (int i = 0; i < 3; i++) begin
            rchk(SSF_ADDR_PAT_LO, i[7:0]);
            rchk(SSF_ADDR_OUT_LO, 8'h10 + i[7:0]);
            host.wr(SSF_ADDR_OUT_HI, 8'h5a);
            rchk(SSF_ADDR_OUT_HI, 8'hc3 + i[7:0]);
        end
        rchk(SSF_ADDR_PAT_LO, 8'h00);
        rchk(SSF_ADDR_CNT_LO, 8'h01);
    endtask

    task automatic t_bypass();
        host.wr(SSF_ADDR_MODE, 8'h00);
        rchk(SSF_ADDR_CNT_LO, 8'h00);
        rchk(SSF_ADDR_PAT_HI, 8'h00);
        rchk(SSF_ADDR_CNT_HI, 8'h10);
        cmp("sample_ready", 8'h01, {7'h0, sample_ready});
    endtask

    task automatic t_cont();
        int got;
        host.cfg(SSF_MODE_CONT);
        push(6, got);
        cmp("accepted", 8'h06, got[7:0]);
        rchk(SSF_ADDR_CNT_HI, 8'hc0, 8'hc0);
        rchk(SSF_ADDR_OUT_LO, 8'h12);
        rchk(SSF_ADDR_OUT_HI, 8'hc5);
        rchk(SSF_ADDR_CNT_HI, 8'h00, 8'h40);
        host.drop_set(3);
        rchk(SSF_ADDR_CNT_HI, 8'h10);
    endtask

    task automatic t_trig();
        int got;
        ssf_mode_t rsv[3] = '{SSF_MODE_RSV2, SSF_MODE_RSV5, SSF_MODE_RSV7};
        foreach (rsv[i]) begin
            host.cfg(rsv[i]);
            push(2, got);
            rchk(SSF_ADDR_CNT_HI, 8'h10);
        end
        host.cfg(SSF_MODE_BYP2CONT);
        push(2, got);
        rchk(SSF_ADDR_CNT_HI, 8'h10);
        mode_trigger = 1'b1;
        repeat (4) @(negedge core_clk);
        push(2, got);
        rchk(SSF_ADDR_CNT_LO, 8'h02);
        host.wr(SSF_ADDR_CTRL4, 8'h00);
        host.wr(SSF_ADDR_WM_LO, 8'h03);
        rchk(SSF_ADDR_CNT_HI, 8'h00);
        host.wr(SSF_ADDR_WM_LO, 8'h02);
        rchk(SSF_ADDR_CNT_HI, 8'h80);
        host.wr(SSF_ADDR_WM_LO, 8'h04);
        host.wr(SSF_ADDR_CTRL4, 8'h01);
        host.cfg(SSF_MODE_CONT2STOP);
        push(50, got);
        cmp("stopped", 8'h01, {7'h0, got < 50 && sample_ready === 1'b0});
        host.drop_set(3);
        rchk(SSF_ADDR_CNT_LO, 8'h01);
        rchk(SSF_ADDR_OUT_LO, 8'h13);
        rchk(SSF_ADDR_OUT_HI, 8'hc6);
        mode_trigger = 1'b0;
    endtask

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        sample_in = '0;
        mode_trigger = 1'b0;
        n_fail = 0;
        tests_run = 0;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_stopfull();
        t_bypass();
        t_cont();
        t_bypass();
        t_trig();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        $display("MISMATCH watchdog expected done seen hang");
        conclude();
    end
endmodule
`default_nettype wire
